// ===== logic/sra_pkg.sv
package sra_pkg;

  // Operating modes
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_PROT = 2'h1;
  localparam logic [1:0] MODE_V86  = 2'h2;

  // Register classes
  localparam logic [3:0] RC_GENERAL = 4'h0;
  localparam logic [3:0] RC_SEGMENT = 4'h1;
  localparam logic [3:0] RC_FLAGS   = 4'h2;
  localparam logic [3:0] RC_CONTROL = 4'h3;
  localparam logic [3:0] RC_GDT     = 4'h4;
  localparam logic [3:0] RC_IDT     = 4'h5;
  localparam logic [3:0] RC_LDT     = 4'h6;
  localparam logic [3:0] RC_TASK    = 4'h7;
  localparam logic [3:0] RC_DEBUG   = 4'h8;
  localparam logic [3:0] RC_TEST    = 4'h9;

  // Operation categories
  localparam logic [3:0] CAT_DATA   = 4'h0;
  localparam logic [3:0] CAT_ARITH  = 4'h1;
  localparam logic [3:0] CAT_SHIFT  = 4'h2;
  localparam logic [3:0] CAT_STRING = 4'h3;
  localparam logic [3:0] CAT_BIT    = 4'h4;
  localparam logic [3:0] CAT_CTRL   = 4'h5;
  localparam logic [3:0] CAT_HLL    = 4'h6;
  localparam logic [3:0] CAT_OS     = 4'h7;
  localparam logic [3:0] CAT_PROC   = 4'h8;
  localparam logic [3:0] CAT_NONE   = 4'hF;

  // Operand locations
  localparam logic [1:0] LOC_REG = 2'h0;
  localparam logic [1:0] LOC_IMM = 2'h1;
  localparam logic [1:0] LOC_MEM = 2'h2;

  // Operand widths
  localparam logic [1:0] W8  = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;

  // Data operations
  localparam logic [3:0] OP_PASS  = 4'h0;
  localparam logic [3:0] OP_ZX    = 4'h1;
  localparam logic [3:0] OP_SX    = 4'h2;
  localparam logic [3:0] OP_CBW   = 4'h3;
  localparam logic [3:0] OP_CWDP  = 4'h4;
  localparam logic [3:0] OP_WORD_TO_DWORD_EXT_CONVERT  = 4'h5;
  localparam logic [3:0] OP_CDQ   = 4'h6;
  localparam logic [3:0] OP_INC   = 4'h7;
  localparam logic [3:0] OP_SUB1  = 4'h8;

  // Selected opcodes
  localparam logic [7:0] OPC_SIZE_PREFIX = 8'h66;
  localparam logic [7:0] OPC_IF_CLEAR    = 8'hFA;
  localparam logic [7:0] OPC_IF_SET      = 8'hFB;
  localparam logic [7:0] OPC_FLAGS_PUSH  = 8'h9C;
  localparam logic [7:0] OPC_FLAGS_POP   = 8'h9D;

  // Queue and limits
  localparam int         QUEUE_DEPTH = 16;
  localparam logic [4:0] QUEUE_FULL  = 5'h10;
  localparam logic [1:0] MAX_OPERANDS = 2'h3;
  localparam logic [1:0] PL_KERNEL   = 2'h0;
  localparam logic [7:0] ONE_BYTE    = 8'h01;
  localparam logic [7:0] TWO_BYTES   = 8'h02;
  localparam logic [31:0] STEP_ONE   = 32'h0000_0001;

  typedef struct packed {
    logic       valid;
    logic       store;
    logic [3:0] rclass;
  } sra_access_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] op;
    logic [1:0] width;
    logic [31:0] src;
  } sra_data_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] count;
    logic [1:0] dst_loc;
    logic [1:0] src_loc;
    logic [3:0] category;
  } sra_decode_t;

endpackage

// ===== logic/sra_fetch_queue.sv
`timescale 1ns/1ps
module sra_fetch_queue (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       flush_i,
  // Fill side
  input  wire logic       wr_valid_i,
  input  wire logic [7:0] wr_byte_i,
  output      logic       wr_ready_o,
  // Drain side
  input  wire logic       rd_ready_i,
  output      logic       rd_valid_o,
  output      logic [7:0] rd_byte_o,
  output      logic [4:0] level_o
);
  logic [7:0] mem [sra_pkg::QUEUE_DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] level;
  logic       push;
  logic       pop;

  assign wr_ready_o = (level != sra_pkg::QUEUE_FULL);
  assign rd_valid_o = (level != 5'h00);
  assign rd_byte_o  = mem[rd_ptr];
  assign level_o    = level;
  assign push       = wr_valid_i && wr_ready_o && !flush_i;
  assign pop        = rd_valid_o && rd_ready_i && !flush_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= wr_byte_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && flush_i)) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      level  <= 5'h00;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      level <= level + {4'h0, push} - {4'h0, pop};
    end
  end

  a_queue_bound: assert property (@(posedge clk_i) disable iff (srst_i)
    level <= sra_pkg::QUEUE_FULL) else $error("queue level above depth");
endmodule

// ===== logic/sra_front_end.sv
`timescale 1ns/1ps
// Contract
// - Protected mode: control, debug, test registers need privilege level zero.
// - Virtual-8086: flag push and pop obey the io privilege threshold.
// - Sixteen instruction bytes are prefetched ahead of execution.
// - Zero to three operands, each from register, immediate or memory.
// - Two-operand forms: reg-reg, mem-reg, imm-reg, reg-mem, imm-mem.
// - Zero-operand ops like interrupt flag clear/set are one byte; one-operand two.
// - Widths 8/16/32; 32-bit code defaults 8 or 32, 16-bit code 8 or 16.
// - A size prefix swaps the default operand width.
// - Instructions classify into nine operation categories.
// - Zero-extending move widens byte or word source.
// - Sign-extending move widens byte or word source.
// - Accumulator conversions byte-word, word-dword both forms, dword-qword.
// - Increment and decrement change the operand by exactly one.
module sra_front_end (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                ce_i,
  // Processor state
  input  wire logic [1:0]          mode_i,
  input  wire logic [1:0]          current_privilege_level_i,
  input  wire logic [1:0]          io_privilege_threshold_i,
  input  wire logic                code32_i,
  // Register access check
  input  wire sra_pkg::sra_access_t acc_i,
  output      logic                acc_grant_o,
  output      logic                reg_write_o,
  output      logic                prot_fault_o,
  // Prefetch
  input  wire logic                fetch_valid_i,
  input  wire logic [7:0]          fetch_byte_i,
  output      logic                fetch_ready_o,
  input  wire logic                flush_i,
  // Decode
  input  wire logic                dec_ready_i,
  input  wire sra_pkg::sra_decode_t dec_i,
  output      logic                dec_valid_o,
  output      logic [7:0]          dec_byte_o,
  output      logic [1:0]          op_width_o,
  output      logic [7:0]          ins_len_o,
  output      logic [3:0]          category_o,
  output      logic                dec_error_o,
  // Data move/convert
  input  wire sra_pkg::sra_data_t  data_i,
  output      logic [31:0]         res_lo_o,
  output      logic [31:0]         res_hi_o,
  output      logic                res_valid_o
);

  typedef enum logic [1:0] {
    SRA_IDLE   = 2'b01,
    SRA_PREFIX = 2'b10
  } sra_dec_state_t;

  sra_dec_state_t state;
  logic           q_valid;
  logic [7:0]     q_byte;
  logic           q_ready;
  logic           q_wr_ready;
  logic [4:0]     q_level;
  logic           allowed;

  // Access table per mode, class and direction
  function automatic logic access_ok(input logic [1:0] mode, input logic [1:0] cpl,
                                     input logic [1:0] io_privilege_threshold, input logic st,
                                     input logic [3:0] rc);
    logic k;
    k = (cpl == sra_pkg::PL_KERNEL);
    access_ok = 1'b0;
    case (mode)
      sra_pkg::MODE_REAL:
        access_ok = (rc != sra_pkg::RC_LDT) && (rc != sra_pkg::RC_TASK);
      sra_pkg::MODE_PROT: begin
        case (rc)
          sra_pkg::RC_GENERAL, sra_pkg::RC_SEGMENT, sra_pkg::RC_FLAGS: access_ok = 1'b1;
          sra_pkg::RC_CONTROL, sra_pkg::RC_DEBUG, sra_pkg::RC_TEST: access_ok = k;
          sra_pkg::RC_GDT, sra_pkg::RC_IDT, sra_pkg::RC_LDT, sra_pkg::RC_TASK:
            access_ok = st || k;
          default: access_ok = 1'b0;
        endcase
      end
      sra_pkg::MODE_V86: begin
        case (rc)
          sra_pkg::RC_GENERAL, sra_pkg::RC_SEGMENT: access_ok = 1'b1;
          sra_pkg::RC_FLAGS: access_ok = (cpl <= io_privilege_threshold);
          sra_pkg::RC_CONTROL, sra_pkg::RC_GDT, sra_pkg::RC_IDT: access_ok = st;
          default: access_ok = 1'b0;
        endcase
      end
      default: access_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] default_width(input logic c32, input logic ovr,
                                               input logic byte_op);
    if (byte_op) begin
      default_width = sra_pkg::W8;
    end else begin
      default_width = (c32 ^ ovr) ? sra_pkg::W32 : sra_pkg::W16;
    end
  endfunction

  function automatic logic [3:0] classify(input logic [7:0] b);
    case (b[7:4])
      4'h0, 4'h8, 4'h9: classify = sra_pkg::CAT_DATA;
      4'h1, 4'h2, 4'h3, 4'h4: classify = sra_pkg::CAT_ARITH;
      4'hD: classify = sra_pkg::CAT_SHIFT;
      4'hA: classify = sra_pkg::CAT_STRING;
      4'hB: classify = sra_pkg::CAT_BIT;
      4'h7, 4'hE: classify = sra_pkg::CAT_CTRL;
      4'h6: classify = sra_pkg::CAT_HLL;
      4'h5, 4'hC: classify = sra_pkg::CAT_OS;
      4'hF: classify = sra_pkg::CAT_PROC;
      default: classify = sra_pkg::CAT_NONE;
    endcase
  endfunction

  assign allowed = access_ok(mode_i, current_privilege_level_i,
                             io_privilege_threshold_i, acc_i.store, acc_i.rclass);

  // Register access gate: write enable never rises on a refused access
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_grant_o  <= 1'b0;
      reg_write_o  <= 1'b0;
      prot_fault_o <= 1'b0;
    end else if (ce_i) begin
      acc_grant_o  <= acc_i.valid && allowed;
      reg_write_o  <= acc_i.valid && allowed && !acc_i.store;
      prot_fault_o <= acc_i.valid && !allowed;
    end
  end

  sra_fetch_queue u_queue (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .flush_i    (flush_i),
    .wr_valid_i (fetch_valid_i),
    .wr_byte_i  (fetch_byte_i),
    .wr_ready_o (q_wr_ready),
    .rd_ready_i (q_ready),
    .rd_valid_o (q_valid),
    .rd_byte_o  (q_byte),
    .level_o    (q_level)
  );

  // Downstream stall holds bytes in the queue so it fills honestly
  assign q_ready = dec_ready_i && !flush_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fetch_ready_o <= 1'b0;
    end else if (ce_i) begin
      fetch_ready_o <= q_wr_ready && (q_level < sra_pkg::QUEUE_FULL - 5'h01);
    end
  end

  // Prefix tracking
  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && flush_i)) begin
      state <= SRA_IDLE;
    end else if (ce_i && q_valid && q_ready) begin
      case (state)
        SRA_IDLE:   state <= (q_byte == sra_pkg::OPC_SIZE_PREFIX) ? SRA_PREFIX : SRA_IDLE;
        SRA_PREFIX: state <= (q_byte == sra_pkg::OPC_SIZE_PREFIX) ? SRA_PREFIX : SRA_IDLE;
        default:    state <= SRA_IDLE;
      endcase
    end
  end

  // Decode output stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dec_valid_o <= 1'b0;
      dec_byte_o  <= 8'h00;
      op_width_o  <= sra_pkg::W16;
      ins_len_o   <= 8'h00;
      category_o  <= sra_pkg::CAT_NONE;
      dec_error_o <= 1'b0;
    end else if (ce_i) begin
      dec_valid_o <= q_valid && q_ready && (q_byte != sra_pkg::OPC_SIZE_PREFIX);
      if (q_valid && q_ready && (q_byte != sra_pkg::OPC_SIZE_PREFIX)) begin
        dec_byte_o <= q_byte;
        op_width_o <= default_width(code32_i, state == SRA_PREFIX, ~q_byte[0]);
        category_o <= classify(q_byte);
        ins_len_o  <= (dec_i.count == 2'h0) ? sra_pkg::ONE_BYTE :
                      (dec_i.count == 2'h1) ? sra_pkg::TWO_BYTES : 8'h00;
        // Reject operand counts, locations or memory-memory pairs not in the set
        dec_error_o <= dec_i.valid && ((dec_i.count > sra_pkg::MAX_OPERANDS) ||
                       (dec_i.dst_loc == 2'h3) || (dec_i.src_loc == 2'h3) ||
                       ((dec_i.count == 2'h2) && (dec_i.dst_loc == sra_pkg::LOC_IMM)) ||
                       ((dec_i.count == 2'h2) && (dec_i.dst_loc == sra_pkg::LOC_MEM) &&
                        (dec_i.src_loc == sra_pkg::LOC_MEM)));
      end
    end
  end

  // Move, conversion and step unit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      res_lo_o    <= 32'h0000_0000;
      res_hi_o    <= 32'h0000_0000;
      res_valid_o <= 1'b0;
    end else if (ce_i) begin
      res_valid_o <= data_i.valid;
      if (data_i.valid) begin
        res_hi_o <= 32'h0000_0000;
        case (data_i.op)
          sra_pkg::OP_ZX:
            res_lo_o <= (data_i.width == sra_pkg::W8) ? {24'h000000, data_i.src[7:0]} :
                        {16'h0000, data_i.src[15:0]};
          sra_pkg::OP_SX:
            res_lo_o <= (data_i.width == sra_pkg::W8) ? {{24{data_i.src[7]}}, data_i.src[7:0]} :
                        {{16{data_i.src[15]}}, data_i.src[15:0]};
          sra_pkg::OP_CBW:
            res_lo_o <= {data_i.src[31:16], {8{data_i.src[7]}}, data_i.src[7:0]};
          sra_pkg::OP_CWDP: begin
            res_lo_o <= data_i.src;
            res_hi_o <= {16'h0000, {16{data_i.src[15]}}};
          end
          sra_pkg::OP_WORD_TO_DWORD_EXT_CONVERT:
            res_lo_o <= {{16{data_i.src[15]}}, data_i.src[15:0]};
          sra_pkg::OP_CDQ: begin
            res_lo_o <= data_i.src;
            res_hi_o <= {32{data_i.src[31]}};
          end
          sra_pkg::OP_INC:  res_lo_o <= data_i.src + sra_pkg::STEP_ONE;
          sra_pkg::OP_SUB1: res_lo_o <= data_i.src - sra_pkg::STEP_ONE;
          default:          res_lo_o <= data_i.src;
        endcase
      end
    end
  end

  a_prot_ctl_kernel: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && acc_i.valid && mode_i == sra_pkg::MODE_PROT && acc_i.rclass == sra_pkg::RC_CONTROL
     && current_privilege_level_i != 2'h0) |=> prot_fault_o && !acc_grant_o)
    else $error("control access granted above level zero");
  a_v86_flags_io: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && acc_i.valid && mode_i == sra_pkg::MODE_V86 && acc_i.rclass == sra_pkg::RC_FLAGS
     && current_privilege_level_i > io_privilege_threshold_i) |=> prot_fault_o)
    else $error("flag op allowed above io threshold");
  a_real_ldt_refused: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && acc_i.valid && mode_i == sra_pkg::MODE_REAL && acc_i.rclass == sra_pkg::RC_LDT)
    |=> prot_fault_o) else $error("real mode selector access allowed");
  a_fault_no_write: assert property (@(posedge clk_i) disable iff (srst_i)
    prot_fault_o |-> !reg_write_o && !acc_grant_o)
    else $error("register written on refused access");
  a_zero_extend: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && data_i.valid && data_i.op == sra_pkg::OP_ZX && data_i.width == sra_pkg::W8)
    |=> res_lo_o[31:8] == 24'h000000) else $error("zero extension wrong");
  a_sign_extend: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && data_i.valid && data_i.op == sra_pkg::OP_SX && data_i.width == sra_pkg::W16)
    |=> res_lo_o[31:16] == {16{$past(data_i.src[15])}}) else $error("sign ext wrong");
  a_qword_convert: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && data_i.valid && data_i.op == sra_pkg::OP_CDQ)
    |=> res_hi_o == {32{$past(data_i.src[31])}}) else $error("qword high wrong");
  a_step_one: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && data_i.valid && data_i.op == sra_pkg::OP_SUB1)
    |=> res_lo_o == $past(data_i.src) - 32'h0000_0001) else $error("step not one");
  a_prefix_width: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && state == SRA_PREFIX && q_valid && q_ready && q_byte[0] && code32_i
     && q_byte != sra_pkg::OPC_SIZE_PREFIX) |=> op_width_o == sra_pkg::W16)
    else $error("prefix did not swap width");

  c_prot_fault: cover property (@(posedge clk_i) prot_fault_o);
  c_prefixed: cover property (@(posedge clk_i) state == SRA_PREFIX ##1 dec_valid_o);
  c_queue_full: cover property (@(posedge clk_i) q_level == sra_pkg::QUEUE_FULL);
  c_cdq: cover property (@(posedge clk_i) res_valid_o && res_hi_o != 32'h0000_0000);
endmodule

// ===== verif/sra_front_end_test.sv
`timescale 1ns/1ps
module sra_front_end_test;
  logic                 clk_i = 1'b0;
  logic                 srst_i = 1'b1;
  logic                 ce_i = 1'b1;
  logic                 flush_i = 1'b0;
  logic                 code32_i = 1'b1;
  logic [1:0]           mode_i = 2'h0;
  logic [1:0]           cur_level = 2'h0;
  logic [1:0]           io_level = 2'h0;
  logic                 fetch_valid_i = 1'b0;
  logic [7:0]           fetch_byte_i = 8'h00;
  logic                 dec_ready_i = 1'b0;
  sra_pkg::sra_access_t acc_i = '0;
  sra_pkg::sra_decode_t dec_i = '0;
  sra_pkg::sra_data_t   data_i = '0;
  logic                 acc_grant_o, reg_write_o, prot_fault_o, fetch_ready_o;
  logic                 dec_valid_o, dec_error_o, res_valid_o;
  logic [7:0]           dec_byte_o, ins_len_o;
  logic [1:0]           op_width_o;
  logic [3:0]           category_o;
  logic [31:0]          res_lo_o, res_hi_o;
  int                   n_mismatch = 0;
  int                   checked = 0;

  sra_front_end i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .mode_i(mode_i),
    .current_privilege_level_i(cur_level), .io_privilege_threshold_i(io_level),
    .code32_i(code32_i), .acc_i(acc_i), .acc_grant_o(acc_grant_o),
    .reg_write_o(reg_write_o), .prot_fault_o(prot_fault_o),
    .fetch_valid_i(fetch_valid_i), .fetch_byte_i(fetch_byte_i),
    .fetch_ready_o(fetch_ready_o), .flush_i(flush_i), .dec_ready_i(dec_ready_i),
    .dec_i(dec_i), .dec_valid_o(dec_valid_o), .dec_byte_o(dec_byte_o),
    .op_width_o(op_width_o), .ins_len_o(ins_len_o), .category_o(category_o),
    .dec_error_o(dec_error_o), .data_i(data_i), .res_lo_o(res_lo_o),
    .res_hi_o(res_hi_o), .res_valid_o(res_valid_o)
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reference access table, kept independent of the design's own helpers
  function automatic logic allowed(input logic [1:0] m, input logic [1:0] cl,
                                   input logic [1:0] io, input logic st, input logic [3:0] rc);
    if (m == sra_pkg::MODE_REAL) return !(rc == sra_pkg::RC_LDT || rc == sra_pkg::RC_TASK);
    if (m == sra_pkg::MODE_PROT) begin
      if (rc <= sra_pkg::RC_FLAGS) return 1'b1;
      if (rc == sra_pkg::RC_CONTROL || rc >= sra_pkg::RC_DEBUG) return cl == 2'h0;
      return st || cl == 2'h0;
    end
    if (rc <= sra_pkg::RC_SEGMENT) return 1'b1;
    if (rc == sra_pkg::RC_FLAGS) return cl <= io;
    if (rc == sra_pkg::RC_CONTROL || rc == sra_pkg::RC_GDT || rc == sra_pkg::RC_IDT) return st;
    return 1'b0;
  endfunction

  task automatic t_access;
    logic e;
    for (int m = 0; m < 3; m++) begin
      for (int j = 0; j < 4; j++) begin
        for (int rc = 0; rc < 10; rc++) begin
          for (int st = 0; st < 2; st++) begin
            e = allowed(m[1:0], j[0] ? 2'h3 : 2'h0, j[1] ? 2'h3 : 2'h0, st[0], rc[3:0]);
            @(posedge clk_i);
            mode_i <= m[1:0];
            cur_level <= j[0] ? 2'h3 : 2'h0;
            io_level <= j[1] ? 2'h3 : 2'h0;
            acc_i <= '{valid: 1'b1, store: st[0], rclass: rc[3:0]};
            @(posedge clk_i);
            acc_i.valid <= 1'b0;
            #1;
            chk(acc_grant_o === e && reg_write_o === (e & !st[0]) && prot_fault_o === !e,
                "access verdict");
          end
        end
      end
    end
    @(posedge clk_i);
    #1;
    chk(acc_grant_o === 1'b0 && prot_fault_o === 1'b0, "access pulse held");
    $display("test access done");
  endtask

  task automatic dop(input logic [3:0] op, input logic [1:0] w, input logic [31:0] src,
                     input logic [31:0] elo, input logic [31:0] ehi,
                     input logic [31:0] mlo, input logic [31:0] mhi);
    @(posedge clk_i);
    data_i <= '{valid: 1'b1, op: op, width: w, src: src};
    @(posedge clk_i);
    data_i.valid <= 1'b0;
    #1;
    chk(res_valid_o === 1'b1 && ((res_lo_o ^ elo) & mlo) === 32'h0 &&
        ((res_hi_o ^ ehi) & mhi) === 32'h0, "data result");
  endtask

  task automatic t_data;
    dop(sra_pkg::OP_ZX, sra_pkg::W8, 32'h8765_43F0, 32'h0000_00F0, '0, '1, '1);
    dop(sra_pkg::OP_ZX, sra_pkg::W16, 32'h8765_C3F0, 32'h0000_C3F0, '0, '1, '1);
    dop(sra_pkg::OP_SX, sra_pkg::W8, 32'h0000_0080, 32'hFFFF_FF80, '0, '1, '1);
    dop(sra_pkg::OP_SX, sra_pkg::W8, 32'hFFFF_FF7F, 32'h0000_007F, '0, '1, '1);
    dop(sra_pkg::OP_SX, sra_pkg::W16, 32'h1234_8001, 32'hFFFF_8001, '0, '1, '1);
    dop(sra_pkg::OP_CBW, sra_pkg::W8, 32'hABCD_0085, 32'hABCD_FF85, '0, '1, '1);
    dop(sra_pkg::OP_CWDP, sra_pkg::W16, 32'h0000_9000, 32'h0000_9000, 32'h0000_FFFF,
        32'h0000_FFFF, 32'h0000_FFFF);
    dop(sra_pkg::OP_WORD_TO_DWORD_EXT_CONVERT, sra_pkg::W16, 32'h1234_7FFF, 32'h0000_7FFF, '0, '1, '1);
    dop(sra_pkg::OP_CDQ, sra_pkg::W32, 32'h8000_0000, 32'h8000_0000, '1, '1, '1);
    dop(sra_pkg::OP_CDQ, sra_pkg::W32, 32'h7FFF_FFFF, 32'h7FFF_FFFF, '0, '1, '1);
    dop(sra_pkg::OP_INC, sra_pkg::W32, 32'hFFFF_FFFF, 32'h0000_0000, '0, '1, '1);
    dop(sra_pkg::OP_INC, sra_pkg::W32, 32'h0000_00FF, 32'h0000_0100, '0, '1, '1);
    dop(sra_pkg::OP_SUB1, sra_pkg::W32, 32'h0000_0000, 32'hFFFF_FFFF, '0, '1, '1);
    $display("test data done");
  endtask

  // One byte leaves the queue; the decoder answer may trail by up to two cycles
  task automatic pop(input logic [1:0] cnt, output logic seen);
    @(posedge clk_i);
    dec_ready_i <= 1'b1;
    dec_i <= '{valid: 1'b1, count: cnt, dst_loc: 2'h0, src_loc: 2'h0, category: 4'h0};
    @(posedge clk_i);
    dec_ready_i <= 1'b0;
    seen = 1'b0;
    for (int k = 0; k < 3 && !seen; k++) begin
      #1;
      if (dec_valid_o === 1'b1) seen = 1'b1;
      else if (k < 2) @(posedge clk_i);
    end
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge clk_i);
    fetch_valid_i <= 1'b1;
    fetch_byte_i <= b;
    @(posedge clk_i);
    fetch_valid_i <= 1'b0;
  endtask

  task automatic t_queue;
    logic [7:0] seq [16];
    logic       pf;
    logic       seen;
    logic [1:0] w;
    seq = '{8'hFA, 8'hFB, 8'h66, 8'hFB, 8'h01, 8'h66, 8'h00, 8'h9D,
            8'h9C, 8'h89, 8'h8B, 8'h03, 8'h05, 8'h04, 8'h0C, 8'hCD};
    pf = 1'b0;
    // Four extra offers prove the queue refuses beyond its depth
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      fetch_valid_i <= 1'b1;
      fetch_byte_i <= seq[i % 16];
    end
    @(posedge clk_i);
    fetch_valid_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(level_o_full() && fetch_ready_o === 1'b0, "queue not full at depth");
    for (int i = 0; i < 16; i++) begin
      pop(i < 8 ? 2'h0 : 2'h1, seen);
      if (seq[i] == sra_pkg::OPC_SIZE_PREFIX) begin
        chk(!seen, "prefix byte reached decoder");
        pf = 1'b1;
      end else begin
        w = !seq[i][0] ? sra_pkg::W8 : ((code32_i ^ pf) ? sra_pkg::W32 : sra_pkg::W16);
        pf = 1'b0;
        chk(seen && dec_byte_o === seq[i] && op_width_o === w, "operand width");
        chk(ins_len_o === (i < 8 ? sra_pkg::ONE_BYTE : sra_pkg::TWO_BYTES), "length");
        chk(category_o <= sra_pkg::CAT_PROC, "category out of range");
      end
    end
    #1;
    chk(i_dut_level() === 5'h00, "queue not empty");
    // A flush must also forget a pending prefix, so the prefix is consumed first
    push(sra_pkg::OPC_SIZE_PREFIX);
    pop(2'h0, seen);
    chk(!seen, "prefix byte reached decoder");
    @(posedge clk_i);
    flush_i <= 1'b1;
    @(posedge clk_i);
    flush_i <= 1'b0;
    push(8'h01);
    pop(2'h0, seen);
    chk(seen && op_width_o === sra_pkg::W32, "prefix survived flush");
    $display("test queue done");
  endtask

  logic [4:0] level_o;
  assign level_o = i_dut.q_level;

  function automatic logic level_o_full();
    return level_o === sra_pkg::QUEUE_FULL;
  endfunction

  function automatic logic [4:0] i_dut_level();
    return level_o;
  endfunction

  // The verdict is only produced as a byte leaves the queue, so one is fed per form
  task automatic derr(input logic [1:0] c, input logic [1:0] d, input logic [1:0] s,
                      input logic e);
    push(8'h01);
    @(posedge clk_i);
    dec_ready_i <= 1'b1;
    dec_i <= '{valid: 1'b1, count: c, dst_loc: d, src_loc: s, category: 4'h0};
    @(posedge clk_i);
    dec_ready_i <= 1'b0;
    dec_i.valid <= 1'b0;
    #1;
    chk(dec_valid_o === 1'b1 && dec_error_o === e, "operand form verdict");
  endtask

  // Clock enable low must hold every output; the held request lands once it rises
  task automatic t_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    mode_i <= sra_pkg::MODE_REAL;
    acc_i <= '{valid: 1'b1, store: 1'b0, rclass: sra_pkg::RC_LDT};
    data_i <= '{valid: 1'b1, op: sra_pkg::OP_INC, width: sra_pkg::W32, src: 32'h0000_0010};
    @(posedge clk_i);
    #1;
    chk(prot_fault_o === 1'b0 && res_valid_o === 1'b0, "outputs moved while frozen");
    @(posedge clk_i);
    ce_i <= 1'b1;
    @(posedge clk_i);
    acc_i.valid <= 1'b0;
    data_i.valid <= 1'b0;
    #1;
    chk(prot_fault_o === 1'b1 && res_lo_o === 32'h0000_0011, "freeze lost request");
    $display("test freeze done");
  endtask

  task automatic t_forms;
    derr(2'h2, sra_pkg::LOC_REG, sra_pkg::LOC_REG, 1'b0);
    derr(2'h2, sra_pkg::LOC_REG, sra_pkg::LOC_MEM, 1'b0);
    derr(2'h2, sra_pkg::LOC_REG, sra_pkg::LOC_IMM, 1'b0);
    derr(2'h2, sra_pkg::LOC_MEM, sra_pkg::LOC_REG, 1'b0);
    derr(2'h2, sra_pkg::LOC_MEM, sra_pkg::LOC_IMM, 1'b0);
    derr(2'h2, sra_pkg::LOC_MEM, sra_pkg::LOC_MEM, 1'b1);
    derr(2'h2, sra_pkg::LOC_IMM, sra_pkg::LOC_REG, 1'b1);
    derr(2'h0, sra_pkg::LOC_REG, sra_pkg::LOC_REG, 1'b0);
    derr(2'h3, sra_pkg::LOC_REG, sra_pkg::LOC_MEM, 1'b0);
    derr(2'h1, 2'h3, sra_pkg::LOC_REG, 1'b1);
    $display("test forms done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk(op_width_o === sra_pkg::W16 && category_o === sra_pkg::CAT_NONE, "reset values");
    t_access();
    t_data();
    t_freeze();
    t_queue();
    t_forms();
    summarize();
  end
endmodule
